// ===== chassis_temp_trigger_regs.sv
/*
  APB register bank for chassis air temperatures and trigger bridge control.
  Holds five sensor readings, the bridge presence view, and per-bridge enable
  and direction registers that steer the trigger line drivers.
  Reads are captured in the setup cycle, so every transfer finishes with no
  wait state. Writes to read-only registers are dropped without an error,
  while unmapped or misaligned addresses raise pslverr and read as zero.
  Assumes sensor readings and presence straps arrive asynchronously from pins,
  and a nonvolatile storage controller on pclk restores and saves settings.
  The storage controller must replay every saved slot after reset; until it
  does, the drivers stay at the factory value of all lines off.
  Restore and save slots are twice the bridge number less two, plus one for
  the direction register.
*/

`timescale 1ns/100ps
`default_nettype none

module chassis_temp_trigger_regs
(
  input  wire logic                pclk,                 // APB clock, 20 MHz.
  input  wire logic                presetn,              // Asynchronous reset, active low.
  input  wire logic                psel,                 // APB select.
  input  wire logic                penable,              // APB access phase.
  input  wire logic                pwrite,               // APB direction, high for write.
  input  wire logic [7:0]          paddr,                // APB byte address.
  input  wire logic [31:0]         pwdata,               // APB write data.
  output logic      [31:0]         prdata,               // APB read data, registered.
  output logic                     pready,               // APB ready, never stalls.
  output logic                     pslverr,              // APB error on unmapped address.
  input  wire logic [4:0][7:0]     sensor_temp,          // Raw readings, 0 inlet, 1-4 outlet.
  input  wire logic [3:0]          bridge_fitted,        // Presence straps, bit 0 bridge 1.
  input  wire logic                nv_load_valid,        // Restore strobe from storage.
  input  wire logic [2:0]          nv_load_index,        // Restore slot, even enable, odd direction.
  input  wire logic [7:0]          nv_load_data,         // Restore value.
  output logic                     nv_store_valid,       // Save strobe toward storage.
  output logic      [2:0]          nv_store_index,       // Save slot, same layout as restore.
  output logic      [7:0]          nv_store_data,        // Save value.
  output logic      [3:0][7:0]     bridge_driver_enable, // Driver enable per bridge and line.
  output logic      [3:0][7:0]     bridge_direction,     // Direction per bridge and line.
  output logic      [3:0][7:0]     forward_up,           // Lower to higher segment drive.
  output logic      [3:0][7:0]     forward_down          // Higher to lower segment drive.
);

  // Shorthand widths taken from the package.
  localparam int RW = chassis_regs_pkg::REG_W;
  localparam int IW = chassis_regs_pkg::INDEX_W;
  localparam int NB = chassis_regs_pkg::BRIDGES;
  localparam int NS = chassis_regs_pkg::SENSORS;
  localparam int NI = chassis_regs_pkg::NV_IDX_W;

  // Synchroniser and filter stages for the sensor readings.
  logic [NS-1:0][RW-1:0] temp_meta_reg;
  logic [NS-1:0][RW-1:0] temp_sync_reg;
  logic [NS-1:0][RW-1:0] temp_prev_reg;
  logic [NS-1:0][RW-1:0] temp_reg;

  // Synchroniser stages for the presence straps.
  logic [NB-1:0]         pres_meta_reg;
  logic [NB-1:0]         pres_sync_reg;

  // Bridge control storage.
  logic [NB-1:0][RW-1:0] enable_reg;
  logic [NB-1:0][RW-1:0] direction_reg;

  // Decode of the current APB address.
  logic [IW-1:0]         index;
  logic                  aligned;
  logic                  mapped;
  logic                  is_control;
  logic [IW-1:0]         control_offset;
  logic [NI-1:0]         control_slot;
  logic [RW-1:0]         read_value;

  // Transfer phases.
  logic                  setup_phase;
  logic                  access_phase;
  logic                  write_control;

  // Per-bridge write and restore strobes, one for each register of a pair.
  logic [NB-1:0]         wr_enable;
  logic [NB-1:0]         wr_direction;
  logic [NB-1:0]         ld_enable;
  logic [NB-1:0]         ld_direction;

  // Store port registers.
  logic                  nv_store_valid_reg;
  logic [NI-1:0]         nv_store_index_reg;
  logic [RW-1:0]         nv_store_data_reg;

  // Read data register.
  logic [31:0]           prdata_reg;

  // Forwarding enables, registered per segment direction.
  logic [NB-1:0][RW-1:0] forward_up_reg;
  logic [NB-1:0][RW-1:0] forward_down_reg;

  // Phase decode of the APB handshake.
  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;

  // Address split into word index and byte offset.
  assign index   = paddr[7:2];
  assign aligned = (paddr[1:0] == chassis_regs_pkg::WORD_ALIGN);

  // Enable and direction registers alternate from the first enable index.
  assign control_offset = index - chassis_regs_pkg::IDX_B1_ENABLE;
  assign control_slot   = control_offset[NI-1:0];

  // Address decode for the control group and the whole map.
  always_comb
  begin
    is_control = 1'b0;
    mapped     = 1'b0;
    if (!aligned)
    begin
      mapped = 1'b0;
    end
    else if ((index >= chassis_regs_pkg::IDX_B1_ENABLE) &&
             (index <= chassis_regs_pkg::IDX_B4_DIRECTION))
    begin
      is_control = 1'b1;
      mapped     = 1'b1;
    end
    else if (index == chassis_regs_pkg::IDX_PRESENCE)
    begin
      mapped = 1'b1;
    end
    else if ((index >= chassis_regs_pkg::IDX_INLET_TEMP) &&
             (index <= chassis_regs_pkg::IDX_OUTLET_TEMP_4))
    begin
      mapped = 1'b1;
    end
    else
    begin
      mapped = 1'b0;
    end
  end

  // A write lands in bridge control only in the access phase; writes to the
  // read-only registers fall away here without an error.
  assign write_control = access_phase && pwrite && is_control;

  // Slot decode shared by software writes and restores: an even slot is the
  // enable register of a bridge and the slot after it is its direction.
  always_comb
  begin
    wr_enable    = '0;
    wr_direction = '0;
    ld_enable    = '0;
    ld_direction = '0;
    for (int b = 0; b < NB; b++)
    begin
      wr_enable[b]    = write_control && (control_slot == NI'(2 * b));
      wr_direction[b] = write_control && (control_slot == NI'(2 * b + 1));
      ld_enable[b]    = nv_load_valid && (nv_load_index == NI'(2 * b));
      ld_direction[b] = nv_load_valid && (nv_load_index == NI'(2 * b + 1));
    end
  end

  // Read multiplexer over the register map, zero for anything unmapped.
  always_comb
  begin
    read_value = chassis_regs_pkg::FACTORY_VALUE;
    if (!aligned)
    begin
      read_value = chassis_regs_pkg::FACTORY_VALUE;
    end
    else if (index == chassis_regs_pkg::IDX_INLET_TEMP)
    begin
      read_value = temp_reg[0];
    end
    else if (index == chassis_regs_pkg::IDX_OUTLET_TEMP_1)
    begin
      read_value = temp_reg[1];
    end
    else if (index == chassis_regs_pkg::IDX_OUTLET_TEMP_2)
    begin
      read_value = temp_reg[2];
    end
    else if (index == chassis_regs_pkg::IDX_OUTLET_TEMP_3)
    begin
      read_value = temp_reg[3];
    end
    else if (index == chassis_regs_pkg::IDX_OUTLET_TEMP_4)
    begin
      read_value = temp_reg[4];
    end
    else if (index == chassis_regs_pkg::IDX_PRESENCE)
    begin
      read_value = {{(RW-NB){1'b0}}, pres_sync_reg};
    end
    else if (is_control && !control_slot[0])
    begin
      read_value = enable_reg[control_slot[NI-1:1]];
    end
    else if (is_control)
    begin
      read_value = direction_reg[control_slot[NI-1:1]];
    end
    else
    begin
      read_value = chassis_regs_pkg::FACTORY_VALUE;
    end
  end

  // Two-flop synchroniser for the sensor readings; only the second stage
  // is read beyond this process, so no logic sees a metastable bit.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      temp_meta_reg <= '0;
      temp_sync_reg <= '0;
    end
    else
    begin
      temp_meta_reg <= sensor_temp;
      temp_sync_reg <= temp_meta_reg;
    end
  end

  // A reading is accepted only once two synchronised samples agree, so a
  // sensor byte caught mid-change never reaches software torn.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      temp_prev_reg <= '0;
      temp_reg      <= '0;
    end
    else
    begin
      temp_prev_reg <= temp_sync_reg;
      for (int s = 0; s < NS; s++)
      begin
        if (temp_sync_reg[s] == temp_prev_reg[s])
        begin
          temp_reg[s] <= temp_sync_reg[s];
        end
      end
    end
  end

  // Two-flop synchroniser for the presence straps; the value read is live.
  // The zero at reset only fills the flops until two edges have passed.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pres_meta_reg <= chassis_regs_pkg::PRES_RESET;
      pres_sync_reg <= chassis_regs_pkg::PRES_RESET;
    end
    else
    begin
      pres_meta_reg <= bridge_fitted;
      pres_sync_reg <= pres_meta_reg;
    end
  end

  // Bridge control storage: factory zero at reset, then restored from
  // storage or written by software. Each register has its own strobes, so a
  // restore aimed at one register is never lost to a write to another; when
  // both hit the same register in one cycle the software write wins.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int b = 0; b < NB; b++)
      begin
        enable_reg[b]    <= chassis_regs_pkg::FACTORY_VALUE;
        direction_reg[b] <= chassis_regs_pkg::FACTORY_VALUE;
      end
    end
    else
    begin
      for (int b = 0; b < NB; b++)
      begin
        if (wr_enable[b])
        begin
          enable_reg[b] <= pwdata[RW-1:0];
        end
        else if (ld_enable[b])
        begin
          enable_reg[b] <= nv_load_data;
        end

        // The direction register of the same bridge is decided on its own.
        if (wr_direction[b])
        begin
          direction_reg[b] <= pwdata[RW-1:0];
        end
        else if (ld_direction[b])
        begin
          direction_reg[b] <= nv_load_data;
        end
      end
    end
  end

  // Every software write to bridge control is offered to storage.
  // A restore is not echoed back, so storage never sees its own data again.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nv_store_valid_reg <= 1'b0;
      nv_store_index_reg <= '0;
      nv_store_data_reg  <= chassis_regs_pkg::FACTORY_VALUE;
    end
    else
    begin
      nv_store_valid_reg <= write_control;
      if (write_control)
      begin
        nv_store_index_reg <= control_slot;
        nv_store_data_reg  <= pwdata[RW-1:0];
      end
    end
  end

  // Read data is captured in the setup phase and shown in the access phase.
  // Capturing early keeps prdata on a flop and still needs no wait state;
  // the value holds until the next read setup.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg <= chassis_regs_pkg::READ_ZERO;
    end
    else if (setup_phase && !pwrite)
    begin
      prdata_reg <= {{(32-RW){1'b0}}, read_value};
    end
  end

  // Per-line forwarding enables derived from enable and direction.
  // They trail the registers by one cycle and leave the block from a flop.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      forward_up_reg   <= '0;
      forward_down_reg <= '0;
    end
    else
    begin
      for (int b = 0; b < NB; b++)
      begin
        forward_up_reg[b]   <= enable_reg[b] & ~direction_reg[b];
        forward_down_reg[b] <= enable_reg[b] & direction_reg[b];
      end
    end
  end

  // The bank never inserts wait states.
  // Read-only writes are accepted quietly; only unmapped or misaligned addresses are refused.
  assign pready  = 1'b1;
  assign pslverr = access_phase && !mapped;

  // Output drive, all from registers.
  assign prdata               = prdata_reg;
  assign nv_store_valid       = nv_store_valid_reg;
  assign nv_store_index       = nv_store_index_reg;
  assign nv_store_data        = nv_store_data_reg;
  assign bridge_driver_enable = enable_reg;
  assign bridge_direction     = direction_reg;
  assign forward_up           = forward_up_reg;
  assign forward_down         = forward_down_reg;

endmodule // chassis_temp_trigger_regs

`default_nettype wire

// ===== chassis_regs_pkg.sv
/*
  Constants for the chassis temperature and trigger bridge register bank:
  register indices, field widths, counts and reset values.
  Assumes a 32-bit APB slave where the byte address is four times the index.
*/
// How it works
// - Five read-only temperature registers sit at consecutive indices, inlet first, then four outlet sensors.
// - Each temperature register shows the unsigned reading on all eight bits at one kelvin per count from zero Celsius.
// - Readings are meaningful from zero to eighty Celsius and the bank passes any other value through unchanged.
// - A read-only presence register sits at the first index of the trigger bridge group.
// - Presence bits 0 to 3 stand for bridges 1 to 4, one meaning fitted, and bits 7 to 4 read zero.
// - The presence register has no reset value of its own and always follows the detected bridges.
// - One read/write driver-enable register per bridge sits at every second index after the presence register.
// - Bit k of a bridge enable register switches that bridge's driver for trigger line k on when one.
// - One read/write direction register per bridge sits directly after that bridge's enable register.
// - A direction bit of zero forwards the line from the lower-numbered slot segment to the higher.
// - A direction bit of one forwards the line from the higher-numbered slot segment to the lower.
// - Enable and direction contents come back from nonvolatile storage and a never-written unit starts at zero.

`default_nettype none

package chassis_regs_pkg;

  // Bus and data widths.
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int REG_W     = 8;
  localparam int INDEX_W   = 6;
  localparam int LINES     = 8;
  localparam int BRIDGES   = 4;
  localparam int SENSORS   = 5;
  localparam int NV_IDX_W  = 3;

  // Register indices; byte address is the index times four.
  localparam logic [INDEX_W-1:0] IDX_INLET_TEMP    = 6'h2C;
  localparam logic [INDEX_W-1:0] IDX_OUTLET_TEMP_1 = 6'h2D;
  localparam logic [INDEX_W-1:0] IDX_OUTLET_TEMP_2 = 6'h2E;
  localparam logic [INDEX_W-1:0] IDX_OUTLET_TEMP_3 = 6'h2F;
  localparam logic [INDEX_W-1:0] IDX_OUTLET_TEMP_4 = 6'h30;
  localparam logic [INDEX_W-1:0] IDX_PRESENCE      = 6'h34;
  localparam logic [INDEX_W-1:0] IDX_B1_ENABLE     = 6'h35;
  localparam logic [INDEX_W-1:0] IDX_B1_DIRECTION  = 6'h36;
  localparam logic [INDEX_W-1:0] IDX_B2_ENABLE     = 6'h37;
  localparam logic [INDEX_W-1:0] IDX_B2_DIRECTION  = 6'h38;
  localparam logic [INDEX_W-1:0] IDX_B3_ENABLE     = 6'h39;
  localparam logic [INDEX_W-1:0] IDX_B3_DIRECTION  = 6'h3A;
  localparam logic [INDEX_W-1:0] IDX_B4_ENABLE     = 6'h3B;
  localparam logic [INDEX_W-1:0] IDX_B4_DIRECTION  = 6'h3C;

  // Byte offset bits that must be zero for an aligned word access.
  localparam logic [1:0] WORD_ALIGN = 2'h0;

  // Reset and factory values.
  localparam logic [REG_W-1:0]  FACTORY_VALUE = 8'h00;
  localparam logic [REG_W-1:0]  TEMP_RESET    = 8'h00;
  localparam logic [BRIDGES-1:0] PRES_RESET   = 4'h0;
  localparam logic [DATA_W-1:0] READ_ZERO     = 32'h0000_0000;

endpackage

`default_nettype wire

// ===== chassis_temp_trigger_regs_props.sv
/*
  Checker for the chassis temperature and trigger bridge register bank.
  Sees only the top module's ports and is bound to every instance of it.
*/

`timescale 1ns/100ps
`default_nettype none

module chassis_temp_trigger_regs_props
(
  input wire logic            pclk,                 // Bus clock.
  input wire logic            presetn,              // Reset, active low.
  input wire logic            psel,                 // Select.
  input wire logic            penable,              // Access phase.
  input wire logic            pwrite,               // Direction.
  input wire logic [7:0]      paddr,                // Byte address.
  input wire logic [31:0]     pwdata,               // Write data.
  input wire logic [31:0]     prdata,               // Read data.
  input wire logic            pslverr,              // Error.
  input wire logic            nv_load_valid,        // Restore strobe.
  input wire logic [2:0]      nv_load_index,        // Restore slot.
  input wire logic [7:0]      nv_load_data,         // Restore value.
  input wire logic            nv_store_valid,       // Save strobe.
  input wire logic [2:0]      nv_store_index,       // Save slot.
  input wire logic [7:0]      nv_store_data,        // Save value.
  input wire logic [3:0][7:0] bridge_driver_enable, // Enables.
  input wire logic [3:0][7:0] bridge_direction,     // Directions.
  input wire logic [3:0][7:0] forward_up,           // Upward drive.
  input wire logic [3:0][7:0] forward_down          // Downward drive.
);
  // All checks run on the bus clock and rest while reset is asserted.
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_bridge1_enable_write: assert property (psel && penable && pwrite && paddr == 8'hD4
    |=> bridge_driver_enable[0] == $past(pwdata[7:0])) else $error("enable write lost");
  chk_bridge4_dir_write: assert property (psel && penable && pwrite && paddr == 8'hF0
    |=> bridge_direction[3] == $past(pwdata[7:0])) else $error("direction write lost");
  chk_store_after_write: assert property (psel && penable && pwrite && paddr == 8'hD4
    |=> nv_store_valid && nv_store_index == 3'h0 && nv_store_data == $past(pwdata[7:0]))
    else $error("write not saved");
  chk_restore_loads_reg: assert property (nv_load_valid && nv_load_index == 3'h3
    && !(psel && penable && pwrite && paddr == 8'hE0)
    |=> bridge_direction[1] == $past(nv_load_data))
    else $error("restore not loaded");
  chk_forward_up_follow: assert property (forward_up ==
    $past(bridge_driver_enable & ~bridge_direction)) else $error("upward drive wrong");
  chk_forward_down_follow: assert property (forward_down ==
    $past(bridge_driver_enable & bridge_direction)) else $error("downward drive wrong");
  chk_disabled_line_idle: assert property ((forward_up | forward_down) ==
    $past(bridge_driver_enable)) else $error("disabled line driven");
  chk_presence_upper_zero: assert property (psel && penable && !pwrite && paddr == 8'hD0
    |-> prdata[31:4] == 28'h0) else $error("presence upper bits set");
  chk_temp_upper_zero: assert property (psel && penable && !pwrite && paddr >= 8'hB0
    && paddr <= 8'hC0 |-> prdata[31:8] == 24'h0) else $error("temperature upper bits set");
  chk_ro_write_no_error: assert property (psel && penable && pwrite
    && (paddr == 8'hB0 || paddr == 8'hD0) |-> !pslverr) else $error("read-only write erred");
  chk_unmapped_error: assert property (psel && penable && !pwrite && paddr == 8'h00
    |-> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
endmodule // chassis_temp_trigger_regs_props

bind chassis_temp_trigger_regs chassis_temp_trigger_regs_props i_props (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr, .nv_load_valid,
  .nv_load_index, .nv_load_data, .nv_store_valid, .nv_store_index, .nv_store_data,
  .bridge_driver_enable, .bridge_direction, .forward_up, .forward_down);

`default_nettype wire

// ===== chassis_temp_trigger_regs_test.sv
/*
  Self-checking bench for the chassis temperature and trigger bridge bank.
  Acts as the bus master and drives sensors, straps and restores itself.
*/

`timescale 1ns/100ps
`default_nettype none

module chassis_temp_trigger_regs_test;
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic            nv_load_valid, nv_store_valid;
  logic [7:0]      paddr, nv_load_data, nv_store_data, en_v, dir_v;
  logic [31:0]     pwdata, prdata, rd;
  logic [4:0][7:0] sensor_temp;
  logic [3:0]      bridge_fitted;
  logic [2:0]      nv_load_index, nv_store_index;
  logic [3:0][7:0] bridge_driver_enable, bridge_direction, forward_up, forward_down;
  int              error_cnt, checked;

  chassis_temp_trigger_regs i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sensor_temp, .bridge_fitted, .nv_load_valid, .nv_load_index,
    .nv_load_data, .nv_store_valid, .nv_store_index, .nv_store_data, .bridge_driver_enable,
    .bridge_direction, .forward_up, .forward_down);

  // Free-running bus clock.
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // One bus transfer; read data and error are taken at the ready edge.
  // It waits for ready with no limit of its own; the watchdog ends a hang.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Restores one slot in the very cycle in which a write reaches its access edge.
  task automatic load_with_write(input logic [7:0] a, input logic [31:0] wd,
                                 input logic [2:0] li, input logic [7:0] ld);
    fork
      xfer(1'b1, a, wd);
      begin
        repeat (2) @(posedge pclk);
        nv_load_valid <= 1'b1;
        nv_load_index <= li;
        nv_load_data <= ld;
        @(posedge pclk);
        nv_load_valid <= 1'b0;
      end
    join
  endtask

  // Compares and counts one value.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("BAD %0t got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic finish_test;
    if (error_cnt == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    {psel, penable, pwrite, nv_load_valid} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    nv_load_index = 3'h0;
    nv_load_data = 8'h00;
    sensor_temp = {8'h50, 8'h00, 8'h13, 8'h20, 8'h33};
    bridge_fitted = 4'hA;
    error_cnt = 0;
    checked = 0;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      xfer(1'b0, 8'hD4 + 8'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    for (int i = 0; i < 5; i++)
    begin
      xfer(1'b1, 8'hB0 + 8'(4 * i), 32'hFF);
      xfer(1'b0, 8'hB0 + 8'(4 * i), 32'h0);
      chk(rd, {24'h0, sensor_temp[i]});
      chk({31'h0, err}, 32'h0);
    end
    xfer(1'b1, 8'hD0, 32'hF);
    xfer(1'b0, 8'hD0, 32'h0);
    chk(rd, 32'hA);
    bridge_fitted <= 4'h5;
    repeat (4) @(posedge pclk);
    xfer(1'b0, 8'hD0, 32'h0);
    chk(rd, 32'h5);
    for (int b = 0; b < 4; b++)
    begin
      en_v = 8'h5A ^ 8'(b * 8'h11);
      dir_v = 8'h0F ^ 8'(b * 8'h30);
      xfer(1'b1, 8'hD4 + 8'(8 * b), {24'hFFFFFF, en_v});
      xfer(1'b1, 8'hD8 + 8'(8 * b), {24'hFFFFFF, dir_v});
      xfer(1'b0, 8'hD4 + 8'(8 * b), 32'h0);
      chk(rd, {24'h0, en_v});
      xfer(1'b0, 8'hD8 + 8'(8 * b), 32'h0);
      chk(rd, {24'h0, dir_v});
      chk({24'h0, forward_up[b]}, {24'h0, en_v & ~dir_v});
      chk({24'h0, forward_down[b]}, {24'h0, en_v & dir_v});
    end
    nv_load_valid <= 1'b1;
    nv_load_index <= 3'h3;
    nv_load_data <= 8'h81;
    @(posedge pclk);
    nv_load_valid <= 1'b0;
    xfer(1'b0, 8'hE0, 32'h0);
    chk(rd, 32'h81);
    load_with_write(8'hD8, 32'h66, 3'h0, 8'h3C);
    xfer(1'b0, 8'hD4, 32'h0);
    chk(rd, 32'h3C);
    xfer(1'b0, 8'hD8, 32'h0);
    chk(rd, 32'h66);
    load_with_write(8'hD4, 32'h99, 3'h0, 8'h11);
    xfer(1'b0, 8'hD4, 32'h0);
    chk(rd, 32'h99);
    xfer(1'b0, 8'h00, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    finish_test;
  end

  // Cuts a hang short well after the sequence should have ended.
  initial
  begin
    repeat (2000) @(posedge pclk);
    error_cnt++;
    finish_test;
  end
endmodule // chassis_temp_trigger_regs_test

`default_nettype wire
